//--- src/mprbs_cfg.svh
// Constants for the module power, reset and boot sequencer.
// Function
// - Five power states: unplugged, off, suspend, running and reset.
// - Main supply applied: go to running by itself, no request needed.
// - Software request suspends from running; a wake event returns to running.
// - Software shutdown from running drops all rails and carrier request, ending off.
// - From off, supply cycling or an external reset request restarts to running.
// - External reset request held low keeps rails on and CPU in reset.
// - Controller enabled only with supply fault high and supported IO strap.
// - Carrier request and IO indication asserted once supply and boot rails are up.
// - Reset output stays asserted at least 10ms after carrier request.
// - Reset output released no earlier than 100ms after carrier request rises.
// - While reset request asserted, internal reset and reset output stay asserted.
// - After reset request release, both resets held at least 1ms more.
// - Boot first from module serial flash, then use the strap selected source.
// - Three active-low straps, strap 2 MSB, decode to eight boot sources.
`ifndef MPRBS_CFG_SVH
`define MPRBS_CFG_SVH
`define MPRBS_CLK_KHZ 20000
`define MPRBS_T_RAMP_MS 100
`define MPRBS_T_RSTOUT_MS 10
`define MPRBS_T_HOLD_MS 1
`define MPRBS_ADR_CTRL 8'h00
`define MPRBS_ADR_STAT 8'h04
`define MPRBS_CTRL_SUSP 0
`define MPRBS_CTRL_SHUT 1
`define MPRBS_CTRL_STAGE 2
`define MPRBS_ST_PSTATE 0
`define MPRBS_ST_FSM 4
`define MPRBS_ST_BOOT 8
`define MPRBS_ST_BVALID 11
`define MPRBS_ST_FIRST 12
`define MPRBS_ST_IO18 13
`define MPRBS_ST_CARD 14
`define MPRBS_PIN_SUPPLY 0
`define MPRBS_PIN_FAULT_N 1
`define MPRBS_PIN_IOSEL 2
`define MPRBS_PIN_MODGOOD 3
`define MPRBS_PIN_RSTREQ_N 4
`define MPRBS_PIN_STRAP 5
`define MPRBS_PIN_CARD 8
`define MPRBS_PIN_WAKE 9
`define MPRBS_PIN_W 10
`endif

//--- src/mprbs_pkg.sv
// Types shared by the sequencer modules.
package mprbs_pkg;
  typedef enum logic [2:0] {
    S_UNPLUG = 3'b000,
    S_OFF = 3'b001,
    S_RAILS = 3'b010,
    S_RAMP = 3'b011,
    S_RUN = 3'b100,
    S_SUSP = 3'b101,
    S_RST = 3'b110,
    S_RSTHOLD = 3'b111
  } mprbs_fsm_t;
  typedef enum logic [2:0] {
    P_UNPLUGGED = 3'b000,
    P_OFF = 3'b001,
    P_SUSPEND = 3'b010,
    P_RUNNING = 3'b011,
    P_RESET = 3'b100
  } mprbs_pstate_t;
  typedef enum logic [2:0] {
    B_CARRIER_SATA = 3'b000,
    B_CARRIER_SD = 3'b001,
    B_CARRIER_EMMC = 3'b010,
    B_CARRIER_SPI = 3'b011,
    B_USB1 = 3'b100,
    B_ETHERNET = 3'b101,
    B_MODULE_EMMC = 3'b110,
    B_MODULE_SPI = 3'b111
  } mprbs_boot_t;
endpackage

//--- src/mprbs_tmr_if.sv
// Handshake between the sequencer and its interval timer.
interface mprbs_tmr_if #(parameter int TMR_W = 22);
  logic start;
  logic [TMR_W-1:0] load;
  logic done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface

//--- src/mprbs_timer.sv
// Interval timer: done rises load+1 cycles after a start pulse.
module mprbs_timer #(parameter int TMR_W = 22) (
  input wire logic core_clk,
  input wire logic rst_b,
  mprbs_tmr_if.tmr t
);
  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;

  // Done is a level so the sequencer may look at it late without missing it.
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    if (t.start) begin
      cnt_nxt = t.load;
      busy_nxt = 1'b1;
      done_nxt = 1'b0;
    end else if (busy_r && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end else if (busy_r) begin
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign t.done = done_r;
endmodule

//--- src/mprbs_top.sv
// Power state, reset and boot source sequencer with a Wishbone register port.
`include "mprbs_cfg.svh"
module mprbs_top import mprbs_pkg::*; #(
  parameter int unsigned RAMP_CYCLES = `MPRBS_T_RAMP_MS * `MPRBS_CLK_KHZ,
  parameter int unsigned RSTOUT_CYCLES = `MPRBS_T_RSTOUT_MS * `MPRBS_CLK_KHZ,
  parameter int unsigned HOLD_CYCLES = `MPRBS_T_HOLD_MS * `MPRBS_CLK_KHZ,
  parameter int TMR_W = 22,
  parameter bit SUPPORT_1V8 = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic supply_present,
  input wire logic supply_fault_n,
  input wire logic io_sel_in,
  output logic io_sel_out,
  output logic io_sel_oe,
  input wire logic module_supplies_good,
  input wire logic reset_request_n,
  input wire logic boot_source_strap_0_n,
  input wire logic boot_source_strap_1_n,
  input wire logic boot_source_strap_2_n,
  input wire logic card_power_strap,
  input wire logic wake_event,
  output logic pmic_enable,
  output logic module_rails_on,
  output logic nonwake_rails_on,
  output logic base_board_power_request,
  output logic cpu_reset_n,
  output logic reset_out_n,
  output logic first_stage_flash,
  output logic [2:0] boot_source,
  output logic boot_source_valid,
  output logic [2:0] power_state
);
  // The reset output must meet both the 10 ms and 100 ms minimums.
  localparam int unsigned RAMP_LOAD = (RAMP_CYCLES > RSTOUT_CYCLES) ? RAMP_CYCLES : RSTOUT_CYCLES;

  mprbs_tmr_if #(.TMR_W(TMR_W)) tmr_bus ();

  mprbs_timer #(.TMR_W(TMR_W)) u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .t(tmr_bus.tmr)
  );

  // Map the sequencer state onto the five externally visible power states.
  function automatic mprbs_pstate_t pstate_of(input mprbs_fsm_t s);
    case (s)
      S_UNPLUG: pstate_of = P_UNPLUGGED;
      S_OFF: pstate_of = P_OFF;
      S_SUSP: pstate_of = P_SUSPEND;
      S_RUN: pstate_of = P_RUNNING;
      default: pstate_of = P_RESET;
    endcase
  endfunction

  // Pins come from the carrier, so each passes two flip-flops first.
  logic [`MPRBS_PIN_W-1:0] pin_raw;
  logic [`MPRBS_PIN_W-1:0] sync1_r;
  logic [`MPRBS_PIN_W-1:0] sync2_r;
  assign pin_raw = {wake_event, card_power_strap, boot_source_strap_2_n,
                    boot_source_strap_1_n, boot_source_strap_0_n, reset_request_n,
                    module_supplies_good, io_sel_in, supply_fault_n, supply_present};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  logic supply_s;
  logic fault_n_s;
  logic io_high_s;
  logic modgood_s;
  logic rreq_n_s;
  logic [2:0] strap_s;
  logic wake_s;
  logic io_ok;
  logic pwr_ok;
  assign supply_s = sync2_r[`MPRBS_PIN_SUPPLY];
  assign fault_n_s = sync2_r[`MPRBS_PIN_FAULT_N];
  assign io_high_s = sync2_r[`MPRBS_PIN_IOSEL];
  assign modgood_s = sync2_r[`MPRBS_PIN_MODGOOD];
  assign rreq_n_s = sync2_r[`MPRBS_PIN_RSTREQ_N];
  assign strap_s = sync2_r[`MPRBS_PIN_STRAP +: 3];
  assign wake_s = sync2_r[`MPRBS_PIN_WAKE];
  // A grounded IO strap means 1.8 V, acceptable only if that level is supported.
  assign io_ok = io_high_s | SUPPORT_1V8;
  assign pwr_ok = supply_s & fault_n_s & io_ok;

  // Wishbone slave: one wait state, ack dropped the cycle after it is given.
  logic wb_req;
  logic wr_ctrl;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [31:0] stat_word;
  logic susp_wr;
  logic shut_wr;
  logic stage_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `MPRBS_ADR_CTRL);
  assign susp_wr = wr_ctrl & wb_dat_i[`MPRBS_CTRL_SUSP];
  assign shut_wr = wr_ctrl & wb_dat_i[`MPRBS_CTRL_SHUT];
  assign stage_wr = wr_ctrl & wb_dat_i[`MPRBS_CTRL_STAGE];

  // Sequencer state and registered outputs.
  mprbs_fsm_t state_r;
  mprbs_fsm_t state_nxt;
  logic ramp_done_r;
  logic ramp_done_nxt;
  logic pmic_r;
  logic pmic_nxt;
  logic rails_r;
  logic rails_nxt;
  logic nonwake_r;
  logic nonwake_nxt;
  logic req_r;
  logic req_nxt;
  logic iooe_r;
  logic iooe_nxt;
  logic ioout_r;
  logic ioout_nxt;
  logic cpurst_n_r;
  logic cpurst_n_nxt;
  logic rstout_n_r;
  logic rstout_n_nxt;
  logic first_r;
  logic first_nxt;
  logic [2:0] boot_r;
  logic [2:0] boot_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [2:0] pstate_r;
  logic [2:0] pstate_nxt;

  // State transitions; supply loss overrides every other cause.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_UNPLUG: if (pwr_ok) state_nxt = S_RAILS;
      S_OFF: begin
        if (!rreq_n_s) state_nxt = S_RST;
      end
      S_RAILS: begin
        if (!rreq_n_s) state_nxt = S_RST;
        else if (modgood_s) state_nxt = S_RAMP;
      end
      S_RAMP: begin
        if (!rreq_n_s) state_nxt = S_RST;
        else if (tmr_bus.done) state_nxt = S_RUN;
      end
      S_RUN: begin
        if (!rreq_n_s) state_nxt = S_RST;
        else if (shut_wr) state_nxt = S_OFF;
        else if (susp_wr) state_nxt = S_SUSP;
      end
      S_SUSP: begin
        if (!rreq_n_s) state_nxt = S_RST;
        else if (wake_s) state_nxt = S_RUN;
      end
      S_RST: if (rreq_n_s) state_nxt = S_RSTHOLD;
      S_RSTHOLD: begin
        if (!rreq_n_s) state_nxt = S_RST;
        else if (tmr_bus.done && ramp_done_r) state_nxt = S_RUN;
        else if (tmr_bus.done) state_nxt = S_RAMP;
      end
      default: state_nxt = S_UNPLUG;
    endcase
    // Leaving the supply behind means a fresh start from unplugged.
    if (!pwr_ok) state_nxt = S_UNPLUG;
  end

  // Start the timer on entry to the ramp wait or the post-reset hold.
  always_comb begin
    tmr_bus.start = 1'b0;
    tmr_bus.load = TMR_W'(RAMP_LOAD);
    if (state_nxt == S_RAMP && state_r != S_RAMP) begin
      tmr_bus.start = 1'b1;
    end else if (state_nxt == S_RSTHOLD && state_r != S_RSTHOLD) begin
      tmr_bus.start = 1'b1;
      tmr_bus.load = TMR_W'(HOLD_CYCLES);
    end
  end

  // Outputs follow the next state so every pin comes from a flip-flop.
  always_comb begin
    pmic_nxt = (state_nxt != S_UNPLUG);
    rails_nxt = !(state_nxt inside {S_UNPLUG, S_OFF});
    nonwake_nxt = rails_nxt && state_nxt != S_SUSP;
    req_nxt = rails_nxt && state_nxt != S_RAILS;
    iooe_nxt = req_nxt;
    ioout_nxt = io_high_s;
    cpurst_n_nxt = state_nxt inside {S_RUN, S_SUSP};
    rstout_n_nxt = cpurst_n_nxt;
    ramp_done_nxt = req_nxt && (ramp_done_r || (state_r == S_RAMP && tmr_bus.done));
    first_nxt = first_r;
    boot_nxt = boot_r;
    bvalid_nxt = bvalid_r;
    if (!cpurst_n_nxt) begin
      first_nxt = 1'b0;
      bvalid_nxt = 1'b0;
    end else if (!cpurst_n_r) begin
      // Straps taken once, at the release of reset, held until the next one.
      boot_nxt = strap_s;
      first_nxt = 1'b1;
    end else if (stage_wr && first_r) begin
      first_nxt = 1'b0;
      bvalid_nxt = 1'b1;
    end
    pstate_nxt = pstate_of(state_nxt);
  end

  // Registers only.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_UNPLUG;
      ramp_done_r <= 1'b0;
      pmic_r <= 1'b0;
      rails_r <= 1'b0;
      nonwake_r <= 1'b0;
      req_r <= 1'b0;
      iooe_r <= 1'b0;
      ioout_r <= 1'b0;
      cpurst_n_r <= 1'b0;
      rstout_n_r <= 1'b0;
      first_r <= 1'b0;
      boot_r <= 3'h0;
      bvalid_r <= 1'b0;
      pstate_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      ramp_done_r <= ramp_done_nxt;
      pmic_r <= pmic_nxt;
      rails_r <= rails_nxt;
      nonwake_r <= nonwake_nxt;
      req_r <= req_nxt;
      iooe_r <= iooe_nxt;
      ioout_r <= ioout_nxt;
      cpurst_n_r <= cpurst_n_nxt;
      rstout_n_r <= rstout_n_nxt;
      first_r <= first_nxt;
      boot_r <= boot_nxt;
      bvalid_r <= bvalid_nxt;
      pstate_r <= pstate_nxt;
    end
  end

  // Status word; unmapped addresses read as zero and are still acknowledged.
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`MPRBS_ST_PSTATE +: 3] = pstate_r;
    stat_word[`MPRBS_ST_FSM +: 3] = state_r;
    stat_word[`MPRBS_ST_BOOT +: 3] = boot_r;
    stat_word[`MPRBS_ST_BVALID] = bvalid_r;
    stat_word[`MPRBS_ST_FIRST] = first_r;
    stat_word[`MPRBS_ST_IO18] = ~io_high_s;
    stat_word[`MPRBS_ST_CARD] = sync2_r[`MPRBS_PIN_CARD];
    ack_nxt = wb_req;
    dat_nxt = 32'h0000_0000;
    if (wb_req && !wb_we_i && wb_adr_i == `MPRBS_ADR_STAT) begin
      dat_nxt = stat_word;
    end else if (wb_req && !wb_we_i && wb_adr_i == `MPRBS_ADR_CTRL) begin
      dat_nxt[`MPRBS_CTRL_STAGE] = bvalid_r;
    end
  end

  // Registers only.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pmic_enable = pmic_r;
  assign module_rails_on = rails_r;
  assign nonwake_rails_on = nonwake_r;
  assign base_board_power_request = req_r;
  assign io_sel_oe = iooe_r;
  assign io_sel_out = ioout_r;
  assign cpu_reset_n = cpurst_n_r;
  assign reset_out_n = rstout_n_r;
  assign first_stage_flash = first_r;
  assign boot_source = boot_r;
  assign boot_source_valid = bvalid_r;
  assign power_state = pstate_r;

  // Helper ages for the timing checks; req_age_r saturates, hold_age_r wraps.
  logic [TMR_W-1:0] req_age_r;
  logic [TMR_W-1:0] hold_age_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_age_r <= '0;
      hold_age_r <= '0;
    end else begin
      req_age_r <= !req_r ? '0 : (&req_age_r ? req_age_r : req_age_r + 1'b1);
      hold_age_r <= (state_r != S_RSTHOLD) ? '0 : hold_age_r + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence seq_suspended;
    state_r == S_SUSP && rreq_n_s && pwr_ok;
  endsequence
  sequence seq_woken;
    wake_s ##1 state_r == S_RUN;
  endsequence

  ramp_min_a: assert property ($rose(reset_out_n) |-> req_age_r >= TMR_W'(RAMP_LOAD))
    else $error("reset output released too soon after carrier request");
  hold_min_a: assert property ($rose(reset_out_n) && $past(state_r == S_RSTHOLD)
      |-> $past(hold_age_r) >= TMR_W'(HOLD_CYCLES))
    else $error("post reset hold shorter than required");
  rstin_hold_a: assert property (!rreq_n_s |=> !reset_out_n && !cpu_reset_n)
    else $error("resets not asserted during reset request");
  auto_run_a: assert property (state_r == S_RAILS && modgood_s && rreq_n_s && pwr_ok
      |=> state_r == S_RAMP && base_board_power_request)
    else $error("no automatic ramp after boot supplies good");
  pmic_gate_a: assert property (pmic_enable |-> $past(pwr_ok))
    else $error("controller enabled without valid supply or strap");
  shut_off_a: assert property (state_r == S_RUN && shut_wr && rreq_n_s && pwr_ok
      |=> state_r == S_OFF && !base_board_power_request && !module_rails_on)
    else $error("shutdown did not drop rails and request");
  susp_wake_a: assert property (seq_suspended ##0 wake_s |-> seq_woken)
    else $error("wake event did not return to running");
  boot_keep_a: assert property (cpu_reset_n && $past(cpu_reset_n) |-> $stable(boot_source))
    else $error("boot source changed without reset");
  req_cause_a: assert property ($rose(base_board_power_request) |-> $past(supply_s && modgood_s)
      || $past(!rreq_n_s))
    else $error("carrier request raised before boot supplies good");
  off_reset_a: assert property (state_r == S_OFF && !rreq_n_s && pwr_ok
      |=> state_r == S_RST ##1 module_rails_on)
    else $error("reset request from off did not power cycle");
  first_stage_a: assert property ($rose(boot_source_valid) |-> $past(stage_wr && first_stage_flash))
    else $error("boot source released before first stage finished");
endmodule

//--- sim/mprbs_carrier_model.sv
// Behavioural carrier board that faces the sequencer: supply, straps, reset and rails.
module mprbs_carrier_model (
  input wire logic core_clk,
  input wire logic main_on,
  input wire logic fault,
  input wire logic io18,
  input wire logic rst_req,
  input wire logic [2:0] strap_gnd,
  input wire logic pmic_enable,
  input wire logic base_board_power_request,
  input wire logic io_sel_out,
  input wire logic io_sel_oe,
  output logic supply_present,
  output logic supply_fault_n,
  output logic io_sel_in,
  output logic reset_request_n,
  output logic boot_source_strap_0_n,
  output logic boot_source_strap_1_n,
  output logic boot_source_strap_2_n,
  output logic card_power_strap,
  output logic module_supplies_good
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] good_sr = 3'h0;
  logic rail_5v_r = 1'b0;
  logic rail_3v3_r = 1'b0;

  // Open-drain lines: the module pull-up wins unless the carrier grounds them.
  assign supply_present = main_on;
  assign supply_fault_n = main_on & ~fault;
  assign io_sel_in = io18 ? 1'b0 : (io_sel_oe ? io_sel_out : 1'b1);
  assign reset_request_n = ~rst_req;
  assign boot_source_strap_0_n = ~strap_gnd[0];
  assign boot_source_strap_1_n = ~strap_gnd[1];
  assign boot_source_strap_2_n = ~strap_gnd[2];
  assign card_power_strap = 1'b1;

  // Module regulators report good a few cycles after the controller is enabled.
  always_ff @(posedge core_clk) begin
    good_sr <= {good_sr[1:0], pmic_enable};
  end
  assign module_supplies_good = good_sr[2];

  // Peripheral rails wait for the request, rise high-first and fall low-first.
  always_ff @(posedge core_clk) begin
    if (base_board_power_request) begin
      rail_5v_r <= 1'b1;
      rail_3v3_r <= rail_5v_r;
    end else begin
      rail_3v3_r <= 1'b0;
      rail_5v_r <= rail_5v_r & rail_3v3_r;
    end
  end
endmodule

//--- sim/tb.sv
// Self-checking bench for the power, reset and boot sequencer.
`include "mprbs_cfg.svh"
module tb import mprbs_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RAMP = 40;
  localparam int RSTOUT = 4;
  localparam int HOLD = 10;
  logic core_clk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, supply_present, supply_fault_n, io_sel_in, io_sel_out, io_sel_oe;
  logic module_supplies_good, reset_request_n, card_power_strap, pmic_enable;
  logic boot_source_strap_0_n, boot_source_strap_1_n, boot_source_strap_2_n;
  logic module_rails_on, nonwake_rails_on, base_board_power_request;
  logic cpu_reset_n, reset_out_n, first_stage_flash, boot_source_valid;
  logic [2:0] boot_source, power_state;
  logic wake_event = 1'b0, main_on = 1'b0, fault = 1'b0, io18 = 1'b0, rst_req = 1'b0;
  logic [2:0] strap_gnd = 3'h0;
  logic rout_prev_r = 1'b0;
  int req_cnt_r = 0, rin_cnt_r = 0, rel_req_r = 0, rel_rin_r = 0;
  int err_total = 0, checks_done = 0;

  mprbs_top #(.RAMP_CYCLES(RAMP), .RSTOUT_CYCLES(RSTOUT), .HOLD_CYCLES(HOLD)) uut (.*);
  mprbs_carrier_model carrier (.*);

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  // Measure how long the reset output stayed low after request rise and pin release.
  always @(posedge core_clk) begin
    req_cnt_r <= base_board_power_request ? req_cnt_r + 1 : 0;
    rin_cnt_r <= reset_request_n ? rin_cnt_r + 1 : 0;
    if (reset_out_n && !rout_prev_r) begin
      rel_req_r <= req_cnt_r;
      rel_rin_r <= rin_cnt_r;
    end
    rout_prev_r <= reset_out_n;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Durations are floors only, so the design may take longer.
  task automatic chk_ge(input int got, input int floor);
    checks_done++;
    if (got < floor) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, floor);
    end
  endtask

  task automatic stop_test();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Classic single Wishbone cycle; held until ack is sampled high.
  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    chk(32'(n < 50), 32'h0000_0001);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Waits on the falling edge so registered outputs have settled.
  task automatic wait_ps(input mprbs_pstate_t ps, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (power_state !== ps && n < lim);
    chk(32'(power_state), 32'(ps));
  endtask

  // A floating strap reads one and strap 2 is the top bit of the code.
  function automatic mprbs_boot_t exp_boot(input logic [2:0] gnd);
    return mprbs_boot_t'(~gnd);
  endfunction

  task automatic reset_pulse(input int len);
    @(posedge core_clk);
    rst_req <= 1'b1;
    tick(len);
    if (len > 4) begin
      chk({reset_out_n, cpu_reset_n, module_rails_on}, 32'h0000_0001);
    end
    rst_req <= 1'b0;
    tick(4);
    chk({reset_out_n, cpu_reset_n, power_state}, 32'(P_RESET));
    wait_ps(P_RUNNING, 400);
    tick(2);
    chk_ge(rel_rin_r, HOLD);
  endtask

  initial begin
    void'($urandom(72142));
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    tick(3);
    chk({pmic_enable, base_board_power_request, reset_out_n, power_state}, 0);
    main_on <= 1'b1;
    wait_ps(P_RUNNING, 400);
    tick(2);
    chk({pmic_enable, module_rails_on, nonwake_rails_on, io_sel_oe, io_sel_out},
        32'h0000_001f);
    chk(base_board_power_request, 1);
    chk_ge(rel_req_r, RAMP);
    chk_ge(rel_req_r, RSTOUT);
    // Every strap code, each after a reset pulse of random length, short ones included.
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      strap_gnd <= ~3'(i);
      reset_pulse(1 + $urandom_range(10));
      chk(boot_source, exp_boot(~3'(i)));
      chk({first_stage_flash, boot_source_valid}, 32'h0000_0002);
      @(posedge core_clk);
      strap_gnd <= 3'($urandom);
      tick(4);
      wb_io(1'b1, `MPRBS_ADR_CTRL, 32'h0000_0004, rd);
      wb_io(1'b0, `MPRBS_ADR_CTRL, 32'h0000_0000, rd);
      chk(rd[2], 1);
      chk({first_stage_flash, boot_source_valid, boot_source}, 32'(8 + i));
    end
    // Unmapped places read as zero and ignore writes.
    repeat (4) begin
      wb_io(1'b1, {6'($urandom_range(63, 2)), 2'b00}, $urandom, rd);
      wb_io(1'b0, {6'($urandom_range(63, 2)), 2'b00}, 32'h0000_0000, rd);
      chk(rd, 0);
    end
    wb_io(1'b0, `MPRBS_ADR_STAT, 32'h0000_0000, rd);
    // The card strap is tied high by the carrier, so the status bit must show it.
    chk({rd[14], rd[13], rd[2:0]}, 32'h0000_0010 | 32'(P_RUNNING));
    // A wake event while running changes nothing.
    @(posedge core_clk);
    wake_event <= 1'b1;
    tick(6);
    wake_event <= 1'b0;
    wait_ps(P_RUNNING, 1);
    wb_io(1'b1, `MPRBS_ADR_CTRL, 32'h0000_0001, rd);
    wait_ps(P_SUSPEND, 20);
    tick(2);
    chk({module_rails_on, nonwake_rails_on, base_board_power_request},
        32'h0000_0005);
    @(posedge core_clk);
    wake_event <= 1'b1;
    wait_ps(P_RUNNING, 20);
    @(posedge core_clk);
    wake_event <= 1'b0;
    // Suspend and shutdown together: shutdown wins, only the controller stays up.
    wb_io(1'b1, `MPRBS_ADR_CTRL, 32'h0000_0003, rd);
    wait_ps(P_OFF, 20);
    tick(2);
    chk({pmic_enable, module_rails_on, nonwake_rails_on, base_board_power_request},
        32'h0000_0008);
    reset_pulse(6);
    chk_ge(rel_req_r, RAMP);
    wb_io(1'b1, `MPRBS_ADR_CTRL, 32'h0000_0002, rd);
    wait_ps(P_OFF, 20);
    @(posedge core_clk);
    main_on <= 1'b0;
    wait_ps(P_UNPLUGGED, 20);
    @(posedge core_clk);
    main_on <= 1'b1;
    wait_ps(P_RUNNING, 400);
    // Supply fault drops power; recovery with a grounded IO strap.
    @(posedge core_clk);
    fault <= 1'b1;
    io18 <= 1'b1;
    wait_ps(P_UNPLUGGED, 20);
    chk(pmic_enable, 0);
    @(posedge core_clk);
    fault <= 1'b0;
    wait_ps(P_RUNNING, 400);
    chk({io_sel_oe, io_sel_out}, 32'h0000_0002);
    wb_io(1'b0, `MPRBS_ADR_STAT, 32'h0000_0000, rd);
    chk(rd[13], 1);
    stop_test();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    stop_test();
  end
endmodule
